/* File: core/butmr_consts.vh */
// Register map, field positions and reset values of the basic upcount timer
`ifndef BUTMR_CONSTS_VH
`define BUTMR_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BUTMR_OFS_CTRL1   6'h00
`define BUTMR_OFS_CTRL2   6'h04
`define BUTMR_OFS_IRQDMA  6'h0C
`define BUTMR_OFS_STATUS  6'h10
`define BUTMR_OFS_EVGEN   6'h14
`define BUTMR_OFS_COUNT   6'h24
`define BUTMR_OFS_PRESC   6'h28
`define BUTMR_OFS_RELOAD  6'h2C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BUTMR_CTL1_RUN     0
`define BUTMR_CTL1_INHIBIT 1
`define BUTMR_CTL1_SRCSEL  2
`define BUTMR_CTL1_SHOT    3
`define BUTMR_CTL1_BUFFER  7
`define BUTMR_CTL2_TSEL_LO 4
`define BUTMR_CTL2_TSEL_HI 6
`define BUTMR_EN_IRQ       0
`define BUTMR_EN_DMA       8
`define BUTMR_SR_FLAG     0
`define BUTMR_EG_UPD      0

// ----------------------------------------
// Master output selection codes
// ----------------------------------------
`define BUTMR_TSEL_REQUEST 3'h0
`define BUTMR_TSEL_ENABLE  3'h1
`define BUTMR_TSEL_UPDATE  3'h2

// ----------------------------------------
// Writable bits of the stored registers
// ----------------------------------------
`define BUTMR_CTL2_WMASK  16'h0070
`define BUTMR_EN_WMASK    16'h0101
`define BUTMR_ALL_WMASK   16'hFFFF

// ----------------------------------------
// Reset value and zero/one constants
// ----------------------------------------
`define BUTMR_RST16       16'h0000
`define BUTMR_ZERO16      16'h0000
`define BUTMR_ONE16       16'h0001

`endif

/* File: core/butmr_regbank.v */
// Write-side register storage of the basic upcount timer configuration
`timescale 1ns/100ps
`default_nettype none
`include "butmr_consts.vh"

module butmr_regbank #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Write port
   input  wire         wr_en,
   input  wire [W-1:0] wr_data,
   input  wire [W-1:0] wr_mask,
   // Stored value
   output reg  [W-1:0] q_reg
);

   reg [W-1:0] q_next;

   always @* begin
      q_next = (q_reg & ~wr_mask) | (wr_data & wr_mask);
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         q_reg <= `BUTMR_RST16;
      end else if (wr_en) begin
         q_reg <= q_next;
      end
   end

endmodule
`default_nettype wire

/* File: core/butmr_timer.v */
// Basic 16-bit upcount timer with prescaler, reload, flag and trigger out
`timescale 1ns/100ps
`default_nettype none
`include "butmr_consts.vh"

module butmr_timer #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Register port
   input  wire         reg_sel,
   input  wire         reg_wr,
   input  wire [5:0]   reg_addr,
   input  wire [1:0]   reg_size,
   input  wire [31:0]  reg_wdata,
   output reg  [31:0]  reg_rdata,
   // Requests to the system
   output reg          irq_req,
   output reg          dma_req,
   output reg          trigger_out
);

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   // any size code but 00: half, word and 11
   // Every accepted size carries the register in the low half; the upper half is ignored
   wire          acc_ok = reg_sel & (reg_size != 2'b00);
   wire          wr     = acc_ok & reg_wr;
   wire [W-1:0]  wd     = reg_wdata[W-1:0];
   wire          wr_cr1 = wr & (reg_addr == `BUTMR_OFS_CTRL1);
   wire          wr_cr2 = wr & (reg_addr == `BUTMR_OFS_CTRL2);
   wire          wr_ie  = wr & (reg_addr == `BUTMR_OFS_IRQDMA);
   wire          wr_sr  = wr & (reg_addr == `BUTMR_OFS_STATUS);
   wire          wr_eg  = wr & (reg_addr == `BUTMR_OFS_EVGEN);
   wire          wr_cnt = wr & (reg_addr == `BUTMR_OFS_COUNT);
   wire          wr_presc  = wr & (reg_addr == `BUTMR_OFS_PRESC);
   wire          wr_reload = wr & (reg_addr == `BUTMR_OFS_RELOAD);
   // Unmapped offsets match no strobe, so writes there are dropped

   // ----------------------------------------
   // Configuration storage
   // ----------------------------------------
   wire [W-1:0]  cr2_q;
   wire [W-1:0]  ie_q;
   wire [W-1:0]  presc_q;
   wire [W-1:0]  reload_q;

   localparam [W-1:0] CR2_MASK = `BUTMR_CTL2_WMASK;
   localparam [W-1:0] IE_MASK  = `BUTMR_EN_WMASK;
   localparam [W-1:0] ALL_MASK = `BUTMR_ALL_WMASK;

   butmr_regbank #(.W(W)) u_cr2 (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_cr2),
      .wr_data (wd),
      .wr_mask (CR2_MASK),
      .q_reg   (cr2_q)
   );
   butmr_regbank #(.W(W)) u_ie (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_ie),
      .wr_data (wd),
      .wr_mask (IE_MASK),
      .q_reg   (ie_q)
   );
   butmr_regbank #(.W(W)) u_presc (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_presc),
      .wr_data (wd),
      .wr_mask (ALL_MASK),
      .q_reg   (presc_q)
   );
   butmr_regbank #(.W(W)) u_reload (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_reload),
      .wr_data (wd),
      .wr_mask (ALL_MASK),
      .q_reg   (reload_q)
   );

   // ----------------------------------------
   // Control register one
   // ----------------------------------------
   reg           count_enable_bit_reg;
   reg           update_inhibit_reg;
   reg           update_source_select_reg;
   reg           single_shot_select_reg;
   reg           reload_buffer_enable_reg;
   reg           internal_count_enable_reg;

   wire [2:0]    master_output_select = cr2_q[`BUTMR_CTL2_TSEL_HI:`BUTMR_CTL2_TSEL_LO];
   wire          update_irq_enable    = ie_q[`BUTMR_EN_IRQ];
   wire          update_dma_enable    = ie_q[`BUTMR_EN_DMA];

   // ----------------------------------------
   // Time base state
   // ----------------------------------------
   reg  [W-1:0]  count_value_reg;
   reg  [W-1:0]  count_value_next;
   reg  [W-1:0]  presc_cnt_reg;
   reg  [W-1:0]  presc_cnt_next;
   reg  [W-1:0]  presc_active_reg;
   reg  [W-1:0]  reload_active_reg;
   reg           update_flag_reg;

   // write one requests, bit never stored
   wire          update_request = wr_eg & wd[`BUTMR_EG_UPD];

   wire          presc_tick = internal_count_enable_reg & (presc_cnt_reg == presc_active_reg);
   wire          cnt_step   = presc_tick & (reload_active_reg != `BUTMR_ZERO16);
   wire          overflow   = cnt_step & (count_value_reg == reload_active_reg);

   wire          update_event = ~update_inhibit_reg & (overflow | update_request);

   wire          flag_set = update_event & (overflow | ~update_source_select_reg);

   // ----------------------------------------
   // Control register one behaviour
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         count_enable_bit_reg     <= 1'b0;
         update_inhibit_reg       <= 1'b0;
         update_source_select_reg <= 1'b0;
         single_shot_select_reg   <= 1'b0;
         reload_buffer_enable_reg <= 1'b0;
      end else begin
         // The hardware clear below comes later, so it wins a same-cycle write
         if (wr_cr1) begin
            count_enable_bit_reg     <= wd[`BUTMR_CTL1_RUN];
            update_inhibit_reg       <= wd[`BUTMR_CTL1_INHIBIT];
            update_source_select_reg <= wd[`BUTMR_CTL1_SRCSEL];
            single_shot_select_reg   <= wd[`BUTMR_CTL1_SHOT];
            reload_buffer_enable_reg <= wd[`BUTMR_CTL1_BUFFER];
         end
         if (update_event & single_shot_select_reg) begin
            count_enable_bit_reg <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         internal_count_enable_reg <= 1'b0;
      end else begin
         internal_count_enable_reg <= count_enable_bit_reg;
      end
   end

   // ----------------------------------------
   // Prescaler and counter
   // ----------------------------------------
   always @* begin
      presc_cnt_next   = presc_cnt_reg;
      count_value_next = count_value_reg;
      if (internal_count_enable_reg) begin
         if (presc_tick) begin
            presc_cnt_next = `BUTMR_ZERO16;
         end else begin
            presc_cnt_next = presc_cnt_reg + `BUTMR_ONE16;
         end
      end
      if (cnt_step) begin
         if (overflow) begin
            count_value_next = `BUTMR_ZERO16;
         end else begin
            count_value_next = count_value_reg + `BUTMR_ONE16;
         end
      end
      if (wr_cnt) begin
         count_value_next = wd;
      end
      if (update_request) begin
         presc_cnt_next   = `BUTMR_ZERO16;
         count_value_next = `BUTMR_ZERO16;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         presc_cnt_reg   <= `BUTMR_RST16;
         count_value_reg <= `BUTMR_RST16;
      end else begin
         presc_cnt_reg   <= presc_cnt_next;
         count_value_reg <= count_value_next;
      end
   end

   // ----------------------------------------
   // Shadow registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         presc_active_reg  <= `BUTMR_RST16;
         reload_active_reg <= `BUTMR_RST16;
      end else begin
         if (update_event) begin
            presc_active_reg  <= presc_q;
            reload_active_reg <= reload_q;
         end
         // unbuffered reload follows preload
         // Buffering keeps a new period from cutting the running one short
         if (!reload_buffer_enable_reg) begin
            reload_active_reg <= reload_q;
         end
      end
   end

   // ----------------------------------------
   // Status flag
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         update_flag_reg <= 1'b0;
      end else if (flag_set) begin
         update_flag_reg <= 1'b1;
      end else if (wr_sr & ~wd[`BUTMR_SR_FLAG]) begin
         update_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt and DMA requests
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         irq_req     <= 1'b0;
         dma_req     <= 1'b0;
      end else begin
         // interrupt gated by enable
         // Level request: it stays up while the flag and its enable are set
         irq_req <= update_irq_enable & (update_flag_reg | flag_set);
         dma_req <= update_dma_enable & flag_set;
      end
   end

   // ----------------------------------------
   // Trigger out
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         trigger_out <= 1'b0;
      end else begin
         case (master_output_select)
            `BUTMR_TSEL_REQUEST: trigger_out <= update_request;
            `BUTMR_TSEL_ENABLE:  trigger_out <= internal_count_enable_reg;
            `BUTMR_TSEL_UPDATE:  trigger_out <= update_event;
            default:             trigger_out <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   reg [W-1:0] rd_mux;

   always @* begin
      rd_mux = `BUTMR_ZERO16;
      case (reg_addr)
         `BUTMR_OFS_CTRL1:  rd_mux = {8'h00, reload_buffer_enable_reg, 3'b000,
                                      single_shot_select_reg, update_source_select_reg,
                                      update_inhibit_reg, count_enable_bit_reg};
         `BUTMR_OFS_CTRL2:  rd_mux = cr2_q;
         `BUTMR_OFS_IRQDMA: rd_mux = ie_q;
         `BUTMR_OFS_STATUS: rd_mux = {15'h0000, update_flag_reg};
         `BUTMR_OFS_COUNT:  rd_mux = count_value_reg;
         // Preload values are read back, not the active shadows
         `BUTMR_OFS_PRESC:  rd_mux = presc_q;
         `BUTMR_OFS_RELOAD: rd_mux = reload_q;
         default:           rd_mux = `BUTMR_ZERO16;
      endcase
   end

   // Registered read data lags the address by one cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (acc_ok & ~reg_wr) begin
         reg_rdata <= {16'h0000, rd_mux};
      end
   end

endmodule
`default_nettype wire

/* File: testbench/butmr_timer_props.sv */
// Port-level assertions for the basic upcount timer
`timescale 1ns/100ps
`default_nettype none
module butmr_timer_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port
   input wire logic        reg_sel,
   input wire logic        reg_wr,
   input wire logic [5:0]  reg_addr,
   input wire logic [1:0]  reg_size,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Requests
   input wire logic        irq_req,
   input wire logic        dma_req,
   input wire logic        trigger_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Size code 11 is never used by the bench, so only 01 and 10 count
   wire ok = reg_sel && (reg_size == 2'b01 || reg_size == 2'b10);
   wire rd = ok && !reg_wr;
   wire wr = ok && reg_wr;
   property p_rd_hi;
      rd |=> reg_rdata[31:16] == 16'h0000;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read half set");
   property p_rsv;
      rd && reg_addr == 6'h00 |=> reg_rdata[15:8] == 8'h00 && reg_rdata[6:4] == 3'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_evg;
      rd && reg_addr == 6'h14 |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_evg: assert property (p_evg) else $error("request bit reads set");
   property p_ug;
      wr && reg_addr == 6'h14 && reg_wdata[0] ##1 rd && reg_addr == 6'h24
         |=> reg_rdata[15:0] == 16'h0000;
   endproperty
   a_ug: assert property (p_ug) else $error("count not restarted");
   property p_stay;
      reg_sel && (reg_wr || reg_size == 2'b00) |=> $stable(reg_rdata);
   endproperty
   a_stay: assert property (p_stay) else $error("read data moved");
   property p_irq_fall;
      $fell(irq_req) |-> $past(wr && (reg_addr == 6'h10 || reg_addr == 6'h0C), 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   property p_rw_back;
      rd && $past(wr) && reg_addr == $past(reg_addr)
         && (reg_addr == 6'h28 || reg_addr == 6'h2C)
         |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2);
   endproperty
   a_rw_back: assert property (p_rw_back) else $error("readback differs");
   property p_cr_back;
      rd && reg_addr == 6'h00 && $past(wr) && $past(reg_addr) == 6'h00
         |=> (reg_rdata[15:0] & 16'h008E) == ($past(reg_wdata[15:0], 2) & 16'h008E);
   endproperty
   a_cr_back: assert property (p_cr_back) else $error("control readback");
   c_irq: cover property ($rose(irq_req));
   c_dma: cover property (dma_req);
   c_trg: cover property (trigger_out);
endmodule
bind butmr_timer butmr_timer_props i_butmr_timer_props (.clk(clk), .rst_n(rst_n),
   .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_size(reg_size),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_req(irq_req),
   .dma_req(dma_req), .trigger_out(trigger_out));
`default_nettype wire

/* File: testbench/butmr_dac_model.sv */
// Converter side: counts trigger and transfer request edges
`timescale 1ns/100ps
`default_nettype none
module butmr_dac_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // From the timer
   input  wire logic        trigger_out,
   input  wire logic        dma_req,
   // Event counts
   output var  logic [15:0] trig_cnt,
   output var  logic [15:0] dma_cnt
);
   logic trig_d;
   logic dma_d;
   always @(posedge clk) begin
      trig_d <= trigger_out && rst_n;
      dma_d  <= dma_req && rst_n;
      if (!rst_n) begin
         trig_cnt <= 16'h0000;
         dma_cnt  <= 16'h0000;
      end else begin
         trig_cnt <= trig_cnt + {15'h0000, trigger_out && !trig_d};
         dma_cnt  <= dma_cnt + {15'h0000, dma_req && !dma_d};
      end
   end
endmodule
`default_nettype wire

/* File: testbench/butmr_timer_tb.sv */
// Self-checking bench of the basic upcount timer
`timescale 1ns/100ps
`default_nettype none
module butmr_timer_tb;
   logic        clk;
   logic        rst_n;
   logic        reg_sel;
   logic        reg_wr;
   logic [5:0]  reg_addr;
   logic [1:0]  reg_size;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        irq_req;
   logic        dma_req;
   logic        trigger_out;
   logic [15:0] trig_cnt;
   logic [15:0] dma_cnt;
   logic [15:0] t0;
   logic [15:0] d0;
   int          miscompares;
   int          total_checks;
   butmr_timer i_butmr_timer (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .irq_req(irq_req), .dma_req(dma_req),
      .trigger_out(trigger_out));
   butmr_dac_model i_butmr_dac_model (.clk(clk), .rst_n(rst_n),
      .trigger_out(trigger_out), .dma_req(dma_req), .trig_cnt(trig_cnt), .dma_cnt(dma_cnt));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Writes leave the strobe up; idle or a read drops it
   task automatic w(input logic [5:0] a, input logic [15:0] v);
      reg_sel   <= 1'b1;
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= {16'h0000, v};
      @(posedge clk);
   endtask
   task automatic r(input logic [5:0] a, input string n, input logic [15:0] e);
      reg_sel  <= 1'b1;
      reg_wr   <= 1'b0;
      reg_addr <= a;
      @(posedge clk);
      reg_sel <= 1'b0;
      @(negedge clk);
      chk(n, reg_rdata[15:0], e);
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      reg_sel <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_irq;
      int i;
      for (i = 0; i < 64 && irq_req !== 1'b1; i++) @(posedge clk);
      if (i == 64) begin
         miscompares++;
         finish_test();
      end
   endtask
   task automatic t_access;
      logic [5:0] m [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h24, 6'h28, 6'h2C};
      foreach (m[k]) r(m[k], "reset value", 16'h0000);
      reg_size <= 2'b10;
      w(6'h00, 16'hFFFE);
      r(6'h00, "control one", 16'h008E);
      reg_size <= 2'b00;
      w(6'h28, 16'h1234);
      reg_size <= 2'b01;
      r(6'h28, "ignored size", 16'h0000);
      w(6'h2C, 16'hA5C3);
      r(6'h2C, "reload readback", 16'hA5C3);
      w(6'h00, 16'h0000);
   endtask
   task automatic t_run;
      w(6'h2C, 16'h0003);
      w(6'h28, 16'h0001);
      w(6'h04, 16'h0020);
      w(6'h0C, 16'h0101);
      w(6'h14, 16'h0001);
      w(6'h10, 16'h0000);
      w(6'h00, 16'h0001);
      idle(1);
      wait_irq();
      t0 = trig_cnt;
      d0 = dma_cnt;
      idle(80);
      chk("trigger pulses", trig_cnt - t0, 16'h000A);
      chk("dma pulses", dma_cnt - d0, 16'h000A);
      w(6'h00, 16'h0000);
      w(6'h10, 16'h0001);
      r(6'h10, "flag kept", 16'h0001);
      w(6'h10, 16'h0000);
      r(6'h10, "flag cleared", 16'h0000);
      chk("irq low", {15'h0000, irq_req}, 16'h0000);
   endtask
   task automatic t_modes;
      w(6'h04, 16'h0000);
      t0 = trig_cnt;
      w(6'h14, 16'h0001);
      idle(3);
      chk("request trigger", trig_cnt - t0, 16'h0001);
      w(6'h04, 16'h0010);
      w(6'h00, 16'h0001);
      idle(3);
      chk("enable trigger", {15'h0000, trigger_out}, 16'h0001);
      w(6'h04, 16'h0030);
      idle(2);
      chk("unlisted trigger", {15'h0000, trigger_out}, 16'h0000);
      w(6'h00, 16'h0000);
      w(6'h10, 16'h0000);
      w(6'h00, 16'h0009);
      idle(1);
      wait_irq();
      idle(2);
      r(6'h00, "single shot stop", 16'h0008);
      r(6'h24, "count wrapped", 16'h0000);
   endtask
   task automatic t_inhibit;
      w(6'h10, 16'h0000);
      w(6'h24, 16'h0007);
      w(6'h00, 16'h0002);
      w(6'h14, 16'h0001);
      r(6'h24, "count restart", 16'h0000);
      r(6'h10, "inhibited flag", 16'h0000);
      r(6'h14, "request clears", 16'h0000);
      d0 = dma_cnt;
      w(6'h00, 16'h0004);
      w(6'h14, 16'h0001);
      r(6'h10, "source flag", 16'h0000);
      chk("source dma", dma_cnt - d0, 16'h0000);
      w(6'h00, 16'h0000);
      w(6'h14, 16'h0001);
      r(6'h10, "request flag", 16'h0001);
   endtask
   task automatic t_reload;
      w(6'h00, 16'h0080);
      w(6'h2C, 16'h0000);
      w(6'h10, 16'h0000);
      w(6'h00, 16'h0081);
      idle(1);
      wait_irq();
      r(6'h10, "buffered reload", 16'h0001);
      w(6'h14, 16'h0001);
      w(6'h10, 16'h0000);
      w(6'h24, 16'h0005);
      idle(20);
      r(6'h24, "frozen count", 16'h0005);
      r(6'h10, "no overflow", 16'h0000);
   endtask
   initial begin
      miscompares = 0;
      total_checks = 0;
      rst_n = 1'b0;
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 6'h00;
      reg_size = 2'b01;
      reg_wdata = 32'h0000_0000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_access();
      t_run();
      t_modes();
      t_inhibit();
      t_reload();
      finish_test();
   end
endmodule
`default_nettype wire
